// ### rtl/exec_pkg.sv
// Purpose: shared constants, opcodes and states of the long-address execution block
// Assumes: 8-bit data path, 16-bit program words, 16-bit program addresses
// Notes: opcode values are local to this block, not the core's instruction encoding
package exec_pkg;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int PWORD_W = 16;
	localparam int PADDR_W = 16;
	localparam int BITSEL_W = 3;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] PTR_STEP = 8'h01;
	// high address byte of the last program page
	localparam logic [7:0] LAST_PAGE_HIGH = 8'hFF;
	// nibble field positions
	localparam int LO_NIB_MSB = 3;
	localparam int HI_NIB_LSB = 4;
	localparam int HI_NIB_MSB = 7;
	// program word byte positions
	localparam int PW_LO_MSB = 7;
	localparam int PW_HI_LSB = 8;
	localparam int PW_HI_MSB = 15;

	// ----------------------------------------
	// opcodes and states
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_SWAP_NIBBLES_INTO_ACC = 4'h0,
		OP_SKIP_IF_ZERO_LONG = 4'h1,
		OP_COPY_SKIP_IF_ZERO_LONG = 4'h2,
		OP_SKIP_IF_BIT_ZERO = 4'h3,
		OP_TABLE_READ_PAGED = 4'h4,
		OP_TABLE_READ_LAST_PAGE = 4'h5,
		OP_INC_TABLE_READ_PAGED = 4'h6,
		OP_INC_TABLE_READ_LAST_PAGE = 4'h7,
		OP_XOR_INTO_ACC = 4'h8,
		OP_XOR_INTO_MEMORY = 4'h9
	} op_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_TADDR = 5'b00010,
		ST_TDATA = 5'b00100,
		ST_SKIP1 = 5'b01000,
		ST_SKIP2 = 5'b10000
	} state_t;

	// ----------------------------------------
	// opcode classes
	// ----------------------------------------
	function automatic logic is_table(input op_t op);
		is_table = (op == OP_TABLE_READ_PAGED) || (op == OP_TABLE_READ_LAST_PAGE) ||
			(op == OP_INC_TABLE_READ_PAGED) || (op == OP_INC_TABLE_READ_LAST_PAGE);
	endfunction : is_table

	function automatic logic is_inc_table(input op_t op);
		is_inc_table = (op == OP_INC_TABLE_READ_PAGED) || (op == OP_INC_TABLE_READ_LAST_PAGE);
	endfunction : is_inc_table

	function automatic logic is_last_page(input op_t op);
		is_last_page = (op == OP_TABLE_READ_LAST_PAGE) || (op == OP_INC_TABLE_READ_LAST_PAGE);
	endfunction : is_last_page

	function automatic logic is_skip_op(input op_t op);
		is_skip_op = (op == OP_SKIP_IF_ZERO_LONG) || (op == OP_COPY_SKIP_IF_ZERO_LONG) ||
			(op == OP_SKIP_IF_BIT_ZERO);
	endfunction : is_skip_op

endpackage : exec_pkg

// ### rtl/exec_if.sv
// Purpose: carrier between the sequencer, the data unit and the pointer unit
// Assumes: all signals on the core clock
// Notes: combinational paths only; state lives in the modules
`timescale 1ns/1ps
interface exec_if;
	import exec_pkg::*;
	op_t op;
	logic [DATA_W-1:0] operand;
	logic [DATA_W-1:0] acc;
	logic [BITSEL_W-1:0] bit_sel;
	logic [DATA_W-1:0] result;
	logic zero;
	logic skip;
	logic ptr_inc;
	logic ptr_last;
	logic [PADDR_W-1:0] addr;

	modport ctrl(output op, operand, acc, bit_sel, ptr_inc, ptr_last,
		input result, zero, skip, addr);
	modport alu(input op, operand, acc, bit_sel, output result, zero, skip);
	modport ptr(input ptr_inc, ptr_last, output addr);
endinterface : exec_if

// ### rtl/data_unit.sv
// Purpose: byte results, zero test and skip condition of the long instructions
// Assumes: operand and accumulator are stable for the whole cycle
// Notes: purely combinational
`timescale 1ns/1ps
module data_unit
	import exec_pkg::*;
(
	exec_if.alu ex
);
	// ----------------------------------------
	// result and conditions
	// ----------------------------------------
	always_comb begin
		case (ex.op)
			OP_SWAP_NIBBLES_INTO_ACC: begin
				ex.result = {ex.operand[LO_NIB_MSB:0], ex.operand[HI_NIB_MSB:HI_NIB_LSB]}; // RULE_01
			end
			OP_XOR_INTO_ACC, OP_XOR_INTO_MEMORY: begin
				ex.result = ex.acc ^ ex.operand; // RULE_10
			end
			default: begin
				ex.result = ex.operand;
			end
		endcase
		ex.zero = (ex.result == BYTE_ZERO);
		case (ex.op)
			OP_SKIP_IF_ZERO_LONG, OP_COPY_SKIP_IF_ZERO_LONG: begin
				ex.skip = (ex.operand == BYTE_ZERO); // RULE_02
			end
			OP_SKIP_IF_BIT_ZERO: begin
				ex.skip = ~ex.operand[ex.bit_sel]; // RULE_05
			end
			default: begin
				ex.skip = 1'b0;
			end
		endcase
	end
endmodule : data_unit

// ### rtl/table_ptr.sv
// Purpose: table pointer pair and program address for table reads
// Assumes: software writes come from the core on the same clock
// Notes: a software write in the same cycle as an increment wins
`timescale 1ns/1ps
module table_ptr
	import exec_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic low_wr_i,
	input wire logic high_wr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [DATA_W-1:0] low_o,
	output logic [DATA_W-1:0] high_o,
	exec_if.ptr ex
);
	logic [DATA_W-1:0] low_q;
	logic [DATA_W-1:0] low_d;
	logic [DATA_W-1:0] high_q;
	logic [DATA_W-1:0] high_d;

	// ----------------------------------------
	// pointer update
	// ----------------------------------------
	always_comb begin
		low_d = low_q;
		high_d = high_q;
		if (ex.ptr_inc) begin
			// 8-bit wrap, never carries into the high pointer
			low_d = low_q + PTR_STEP; // RULE_12
		end
		if (low_wr_i) begin
			low_d = wdata_i;
		end
		if (high_wr_i) begin
			high_d = wdata_i;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			low_q <= BYTE_RESET;
			high_q <= BYTE_RESET;
		end else begin
			low_q <= low_d;
			high_q <= high_d;
		end
	end

	// ----------------------------------------
	// program address
	// ----------------------------------------
	always_comb begin
		if (ex.ptr_last) begin
			ex.addr = {LAST_PAGE_HIGH, low_q}; // RULE_07
		end else begin
			ex.addr = {high_q, low_q}; // RULE_06
		end
	end

	assign low_o = low_q;
	assign high_o = high_q;
endmodule : table_ptr

// ### rtl/long_exec.sv
// Purpose: executes swap, skip, table read and xor long-address instructions
// Assumes: operand byte and program word come from same-clock core logic
// Notes: one instruction at a time; taken skips take three cycles, table reads three
//
// How it works
// RULE_01: swap copies operand nibbles crossed into accumulator; memory and flags untouched.
// RULE_02: byte skip writes operand back unchanged and skips when it is zero.
// RULE_03: a taken skip adds a dummy cycle, three cycles in all.
// RULE_04: copy-skip loads operand into accumulator, skips when it is zero.
// RULE_05: bit skip tests the chosen bit and skips when it is zero.
// RULE_06: paged table read uses both pointers; low byte to memory, high to register.
// RULE_07: last-page table read uses the low pointer inside the last page.
// RULE_08: increment paged read bumps the low pointer, then reads with it.
// RULE_09: increment last-page read bumps the low pointer, then reads last page.
// RULE_10: xor into accumulator stores accumulator xor operand; only zero flag changes.
// RULE_11: xor into memory writes the xor back; accumulator kept, zero flag updated.
// RULE_12: low pointer increment wraps at 256 and never touches the high pointer.
`timescale 1ns/1ps
module long_exec
	import exec_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic instr_valid_i,
	input wire op_t instr_op_i,
	input wire logic [BITSEL_W-1:0] bit_sel_i,
	input wire logic [DATA_W-1:0] mem_rdata_i,
	input wire logic [PWORD_W-1:0] prog_data_i,
	input wire logic ptr_low_wr_i,
	input wire logic ptr_high_wr_i,
	input wire logic [DATA_W-1:0] ptr_wdata_i,
	output logic instr_ready_o,
	output logic done_o,
	output logic skip_o,
	output logic dummy_cycle_o,
	output logic [DATA_W-1:0] accumulator_o,
	output logic zero_flag_o,
	output logic mem_we_o,
	output logic [DATA_W-1:0] mem_wdata_o,
	output logic prog_rd_o,
	output logic [PADDR_W-1:0] prog_addr_o,
	output logic [DATA_W-1:0] table_read_high_byte_o,
	output logic [DATA_W-1:0] table_pointer_low_o,
	output logic [DATA_W-1:0] table_pointer_high_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	state_t state_q;
	state_t state_d;
	logic [DATA_W-1:0] acc_q;
	logic [DATA_W-1:0] acc_d;
	logic zero_q;
	logic zero_d;
	logic we_q;
	logic we_d;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] wdata_d;
	logic [DATA_W-1:0] table_read_high_byte_q;
	logic [DATA_W-1:0] table_read_high_byte_d;
	logic done_q;
	logic done_d;
	logic skip_q;
	logic skip_d;
	logic last_q;
	logic last_d;
	logic take;

	exec_if ex();

	// ----------------------------------------
	// sub units
	// ----------------------------------------
	data_unit u_data (
		.ex(ex.alu)
	);

	table_ptr u_ptr (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.low_wr_i(ptr_low_wr_i),
		.high_wr_i(ptr_high_wr_i),
		.wdata_i(ptr_wdata_i),
		.low_o(table_pointer_low_o),
		.high_o(table_pointer_high_o),
		.ex(ex.ptr)
	);

	assign take = instr_valid_i && (state_q == ST_IDLE);
	assign ex.op = instr_op_i;
	assign ex.operand = mem_rdata_i;
	assign ex.acc = acc_q;
	assign ex.bit_sel = bit_sel_i;
	// pointer moves at the accept edge so the read cycle already sees it
	assign ex.ptr_inc = take && is_inc_table(instr_op_i); // RULE_08 RULE_09
	assign ex.ptr_last = last_q;

	// ----------------------------------------
	// sequencer next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		zero_d = zero_q;
		we_d = 1'b0;
		wdata_d = wdata_q;
		table_read_high_byte_d = table_read_high_byte_q;
		done_d = 1'b0;
		skip_d = 1'b0;
		last_d = last_q;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					case (instr_op_i)
						OP_SWAP_NIBBLES_INTO_ACC: begin
							acc_d = ex.result; // RULE_01
						end
						OP_SKIP_IF_ZERO_LONG: begin
							we_d = 1'b1; // RULE_02
							wdata_d = mem_rdata_i; // RULE_02
						end
						OP_COPY_SKIP_IF_ZERO_LONG: begin
							acc_d = mem_rdata_i; // RULE_04
						end
						OP_XOR_INTO_ACC: begin
							acc_d = ex.result; // RULE_10
							zero_d = ex.zero; // RULE_10
						end
						OP_XOR_INTO_MEMORY: begin
							we_d = 1'b1; // RULE_11
							wdata_d = ex.result; // RULE_11
							zero_d = ex.zero; // RULE_11
						end
						default: begin
						end
					endcase
					if (is_table(instr_op_i)) begin
						last_d = is_last_page(instr_op_i); // RULE_07
						state_d = ST_TADDR;
					end else if (is_skip_op(instr_op_i) && ex.skip) begin
						skip_d = 1'b1; // RULE_03
						state_d = ST_SKIP1; // RULE_03
					end else begin
						done_d = 1'b1;
					end
				end
			end
			ST_TADDR: begin
				// program memory answers one cycle after the address
				state_d = ST_TDATA;
			end
			ST_TDATA: begin
				we_d = 1'b1; // RULE_06
				wdata_d = prog_data_i[PW_LO_MSB:0]; // RULE_06
				table_read_high_byte_d = prog_data_i[PW_HI_MSB:PW_HI_LSB]; // RULE_06
				done_d = 1'b1;
				state_d = ST_IDLE;
			end
			ST_SKIP1: begin
				state_d = ST_SKIP2; // RULE_03
			end
			ST_SKIP2: begin
				done_d = 1'b1;
				state_d = ST_IDLE; // RULE_03
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			acc_q <= BYTE_RESET;
			zero_q <= 1'b0;
			we_q <= 1'b0;
			wdata_q <= BYTE_RESET;
			table_read_high_byte_q <= BYTE_RESET;
			done_q <= 1'b0;
			skip_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			zero_q <= zero_d;
			we_q <= we_d;
			wdata_q <= wdata_d;
			table_read_high_byte_q <= table_read_high_byte_d;
			done_q <= done_d;
			skip_q <= skip_d;
			last_q <= last_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign instr_ready_o = (state_q == ST_IDLE);
	assign done_o = done_q;
	assign skip_o = skip_q;
	// the slot where the fetched next instruction is discarded
	assign dummy_cycle_o = (state_q == ST_SKIP2); // RULE_03
	assign accumulator_o = acc_q;
	assign zero_flag_o = zero_q;
	assign mem_we_o = we_q;
	assign mem_wdata_o = wdata_q;
	assign prog_rd_o = (state_q == ST_TADDR);
	assign prog_addr_o = ex.addr;
	assign table_read_high_byte_o = table_read_high_byte_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (reset_i);

	a_swap_cross: assert property ( // RULE_01
		take && instr_op_i == OP_SWAP_NIBBLES_INTO_ACC |=>
		accumulator_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])}
		&& $stable(zero_flag_o) && !mem_we_o)
		else $error("swap result wrong");

	a_zero_writeback: assert property ( // RULE_02
		take && instr_op_i == OP_SKIP_IF_ZERO_LONG |=>
		mem_we_o && mem_wdata_o == $past(mem_rdata_i) && skip_o == ($past(mem_rdata_i) == 8'h00))
		else $error("byte skip write back wrong");

	a_skip_three: assert property ( // RULE_03
		take && is_skip_op(instr_op_i) && ex.skip |=>
		skip_o ##0 (!instr_ready_o)[*2] ##1 instr_ready_o)
		else $error("skip not three cycles");

	a_noskip_one: assert property ( // RULE_03
		take && is_skip_op(instr_op_i) && !ex.skip |=> instr_ready_o && !skip_o && done_o)
		else $error("non skip held the sequencer");

	a_copy_load: assert property ( // RULE_04
		take && instr_op_i == OP_COPY_SKIP_IF_ZERO_LONG |=>
		accumulator_o == $past(mem_rdata_i) && $stable(zero_flag_o))
		else $error("copy skip load wrong");

	a_bit_test: assert property ( // RULE_05
		take && instr_op_i == OP_SKIP_IF_BIT_ZERO |=>
		skip_o == !$past(mem_rdata_i[bit_sel_i]) && $stable(zero_flag_o))
		else $error("bit skip decision wrong");

	a_table_paged: assert property ( // RULE_06
		prog_rd_o && !last_q |-> prog_addr_o == {table_pointer_high_o, table_pointer_low_o})
		else $error("paged table address wrong");

	a_table_data: assert property ( // RULE_06
		prog_rd_o |=> ##1 mem_we_o && done_o && mem_wdata_o == $past(prog_data_i[7:0])
		&& table_read_high_byte_o == $past(prog_data_i[15:8]))
		else $error("table data not stored");

	a_table_last: assert property ( // RULE_07
		prog_rd_o && last_q |-> prog_addr_o == {8'hFF, table_pointer_low_o})
		else $error("last page address wrong");

	a_inc_first: assert property ( // RULE_08
		take && is_inc_table(instr_op_i) && !ptr_low_wr_i && !ptr_high_wr_i |=>
		prog_rd_o && table_pointer_low_o == 8'($past(table_pointer_low_o) + 8'h01)
		&& $stable(table_pointer_high_o))
		else $error("pointer not incremented before read");

	a_inc_wrap: assert property ( // RULE_12
		take && is_inc_table(instr_op_i) && table_pointer_low_o == 8'hFF
		&& !ptr_low_wr_i && !ptr_high_wr_i |=>
		table_pointer_low_o == 8'h00 && $stable(table_pointer_high_o))
		else $error("pointer wrap carried");

	a_xor_acc: assert property ( // RULE_10
		take && instr_op_i == OP_XOR_INTO_ACC |=>
		accumulator_o == ($past(accumulator_o) ^ $past(mem_rdata_i))
		&& zero_flag_o == (accumulator_o == 8'h00) && !mem_we_o)
		else $error("xor into accumulator wrong");

	a_xor_mem: assert property ( // RULE_11
		take && instr_op_i == OP_XOR_INTO_MEMORY |=>
		mem_we_o && mem_wdata_o == ($past(accumulator_o) ^ $past(mem_rdata_i))
		&& $stable(accumulator_o) && zero_flag_o == (mem_wdata_o == 8'h00))
		else $error("xor into memory wrong");

	c_skip_taken: cover property (take && is_skip_op(instr_op_i) && ex.skip ##3 done_o);
	c_last_inc: cover property (take && instr_op_i == OP_INC_TABLE_READ_LAST_PAGE ##3 done_o);
	c_xor_zero: cover property (take && instr_op_i == OP_XOR_INTO_ACC ##1 zero_flag_o);
	c_bit_skip: cover property (take && instr_op_i == OP_SKIP_IF_BIT_ZERO && ex.skip ##2 dummy_cycle_o);

	// the discarded fetch sits between the skip pulse and the completion
	a_dummy_slot: assert property ( // RULE_03
		skip_o && !done_o |=> dummy_cycle_o && !instr_ready_o ##1 done_o && !dummy_cycle_o)
		else $error("dummy slot misplaced");

	a_table_busy: assert property ( // RULE_06
		take && is_table(instr_op_i) |=> prog_rd_o && !instr_ready_o
		##1 !prog_rd_o && !instr_ready_o ##1 instr_ready_o)
		else $error("table read sequence wrong");

	a_high_kept: assert property ( // RULE_12
		ex.ptr_inc && !ptr_high_wr_i |=> $stable(table_pointer_high_o))
		else $error("increment touched the high pointer");

endmodule : long_exec

// ### test/test_ext_instr_swap_skip_table_xor.sv
// Purpose: self-checking bench for the long-address swap, skip, table read and xor unit
// Assumes: one-cycle synchronous program memory modelled by the bench on prog_data_i
// Notes: expectations come from a small bench-side model of accumulator, flag and pointers
`timescale 1ns/1ps
module test_ext_instr_swap_skip_table_xor;
	import exec_pkg::*;
	typedef struct {op_t op; logic [2:0] bs; logic [7:0] m; logic [15:0] w; logic sk;} row_t;
	logic clock_i, reset_i, instr_valid_i, ptr_low_wr_i, ptr_high_wr_i;
	op_t instr_op_i;
	logic [2:0] bit_sel_i;
	logic [7:0] mem_rdata_i, ptr_wdata_i;
	logic [15:0] prog_data_i;
	logic instr_ready_o, done_o, skip_o, dummy_cycle_o, zero_flag_o, mem_we_o, prog_rd_o;
	logic [7:0] accumulator_o, mem_wdata_o, table_read_high_byte_o;
	logic [7:0] table_pointer_low_o, table_pointer_high_o;
	logic [15:0] prog_addr_o;
	int failures, n_checks;
	int cyc = 0;
	logic [7:0] acc_m, lo_m, hi_m, th_m;
	logic z_m;
	row_t rows [0:15] = '{
		'{OP_SWAP_NIBBLES_INTO_ACC, 3'h0, 8'hA5, 16'h0000, 1'h0},
		'{OP_XOR_INTO_ACC, 3'h0, 8'h5A, 16'h0000, 1'h0},
		'{OP_XOR_INTO_ACC, 3'h0, 8'h3C, 16'h0000, 1'h0},
		'{OP_XOR_INTO_MEMORY, 3'h0, 8'h3C, 16'h0000, 1'h0},
		'{OP_XOR_INTO_MEMORY, 3'h0, 8'h0F, 16'h0000, 1'h0},
		'{OP_SKIP_IF_ZERO_LONG, 3'h0, 8'h80, 16'h0000, 1'h0},
		'{OP_SKIP_IF_ZERO_LONG, 3'h0, 8'h00, 16'h0000, 1'h1},
		'{OP_COPY_SKIP_IF_ZERO_LONG, 3'h0, 8'h00, 16'h0000, 1'h1},
		'{OP_COPY_SKIP_IF_ZERO_LONG, 3'h0, 8'h7E, 16'h0000, 1'h0},
		'{OP_SKIP_IF_BIT_ZERO, 3'h7, 8'h7F, 16'h0000, 1'h1},
		'{OP_SKIP_IF_BIT_ZERO, 3'h0, 8'h01, 16'h0000, 1'h0},
		'{OP_SKIP_IF_BIT_ZERO, 3'h3, 8'hF7, 16'h0000, 1'h1},
		'{OP_TABLE_READ_PAGED, 3'h0, 8'h00, 16'hBEEF, 1'h0},
		'{OP_TABLE_READ_LAST_PAGE, 3'h0, 8'h00, 16'h1234, 1'h0},
		'{OP_INC_TABLE_READ_PAGED, 3'h0, 8'h00, 16'hA55A, 1'h0},
		'{OP_INC_TABLE_READ_LAST_PAGE, 3'h0, 8'h00, 16'h0FF0, 1'h0}};

	long_exec u_dut (.clock_i(clock_i), .reset_i(reset_i), .instr_valid_i(instr_valid_i),
		.instr_op_i(instr_op_i), .bit_sel_i(bit_sel_i), .mem_rdata_i(mem_rdata_i),
		.prog_data_i(prog_data_i), .ptr_low_wr_i(ptr_low_wr_i), .ptr_high_wr_i(ptr_high_wr_i),
		.ptr_wdata_i(ptr_wdata_i), .instr_ready_o(instr_ready_o), .done_o(done_o),
		.skip_o(skip_o), .dummy_cycle_o(dummy_cycle_o), .accumulator_o(accumulator_o),
		.zero_flag_o(zero_flag_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
		.prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
		.table_read_high_byte_o(table_read_high_byte_o),
		.table_pointer_low_o(table_pointer_low_o), .table_pointer_high_o(table_pointer_high_o));

	// ----------------------------------------
	// clock, timeout and reporting
	// ----------------------------------------
	initial begin
		clock_i = 1'h0;
		forever #25 clock_i = ~clock_i;
	end

	// the whole run needs about 50 cycles; the ceiling leaves ample margin
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 600) begin
			failures++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic chk8(input logic [7:0] seen, input logic [7:0] exp);
		chk({8'h00, seen}, {8'h00, exp});
	endtask : chk8

	task automatic chk1(input logic seen, input logic exp);
		chk({15'h0000, seen}, {15'h0000, exp});
	endtask : chk1

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic wr_ptr(input logic hi, input logic [7:0] v);
		ptr_high_wr_i = hi;
		ptr_low_wr_i = ~hi;
		ptr_wdata_i = v;
		@(posedge clock_i);
		#5;
		ptr_low_wr_i = 1'h0;
		ptr_high_wr_i = 1'h0;
		@(posedge clock_i);
		#5;
	endtask : wr_ptr

	// one-cycle ops leave valid up so the next row goes back to back
	task automatic run(input row_t r);
		logic [7:0] ea, wd;
		logic [15:0] ad;
		logic ez, we, tab;
		ea = acc_m;
		ez = z_m;
		we = 1'h0;
		wd = 8'h00;
		tab = 1'h0;
		ad = 16'h0000;
		case (r.op)
			OP_SWAP_NIBBLES_INTO_ACC: ea = {r.m[3:0], r.m[7:4]};
			OP_SKIP_IF_ZERO_LONG: begin
				we = 1'h1;
				wd = r.m;
			end
			OP_COPY_SKIP_IF_ZERO_LONG: ea = r.m;
			OP_XOR_INTO_ACC: begin
				ea = acc_m ^ r.m;
				ez = (ea == 8'h00);
			end
			OP_XOR_INTO_MEMORY: begin
				we = 1'h1;
				wd = acc_m ^ r.m;
				ez = (wd == 8'h00);
			end
			OP_SKIP_IF_BIT_ZERO: ;
			default: begin
				tab = 1'h1;
				wd = r.w[7:0];
				if (r.op == OP_INC_TABLE_READ_PAGED || r.op == OP_INC_TABLE_READ_LAST_PAGE)
					lo_m = lo_m + 8'h01;
				if (r.op == OP_TABLE_READ_LAST_PAGE || r.op == OP_INC_TABLE_READ_LAST_PAGE)
					ad = {8'hFF, lo_m};
				else
					ad = {hi_m, lo_m};
			end
		endcase
		chk1(instr_ready_o, 1'h1);
		instr_valid_i = 1'h1;
		instr_op_i = r.op;
		bit_sel_i = r.bs;
		mem_rdata_i = r.m;
		@(posedge clock_i);
		#5;
		if (tab || r.sk) begin
			instr_valid_i = 1'h0;
			mem_rdata_i = ~r.m;
		end
		chk1(skip_o, r.sk);
		chk1(done_o, ~(tab | r.sk));
		if (!tab)
			chk1(mem_we_o, we);
		if (we)
			chk8(mem_wdata_o, wd);
		if (tab) begin
			chk1(prog_rd_o, 1'h1);
			chk(prog_addr_o, ad);
			chk8(table_pointer_low_o, lo_m);
			chk8(table_pointer_high_o, hi_m);
			@(posedge clock_i);
			#5;
			prog_data_i = r.w;
			@(posedge clock_i);
			#5;
			prog_data_i = ~r.w;
			chk1(mem_we_o, 1'h1);
			chk8(mem_wdata_o, wd);
			th_m = r.w[15:8];
			chk8(table_pointer_low_o, lo_m);
		end
		if (r.sk) begin
			chk1(instr_ready_o, 1'h0);
			@(posedge clock_i);
			#5;
			chk1(dummy_cycle_o, 1'h1);
			@(posedge clock_i);
			#5;
			chk1(dummy_cycle_o, 1'h0);
		end
		chk1(done_o, 1'h1);
		chk1(instr_ready_o, 1'h1);
		chk8(accumulator_o, ea);
		chk1(zero_flag_o, ez);
		chk8(table_read_high_byte_o, th_m);
		acc_m = ea;
		z_m = ez;
	endtask : run

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_i = 1'h1;
		failures = 0;
		n_checks = 0;
		{instr_valid_i, ptr_low_wr_i, ptr_high_wr_i} = 3'h0;
		instr_op_i = OP_SWAP_NIBBLES_INTO_ACC;
		bit_sel_i = 3'h0;
		{mem_rdata_i, ptr_wdata_i, prog_data_i} = 32'h0000_0000;
		{acc_m, lo_m, hi_m, th_m, z_m} = 33'h0;
		repeat (8) @(posedge clock_i);
		#5;
		reset_i = 1'h0;
		chk8(accumulator_o, 8'h00);
		chk1(zero_flag_o, 1'h0);
		chk(prog_addr_o, 16'h0000);
		chk1(instr_ready_o, 1'h1);
		$display("test reset done");
		wr_ptr(1'h0, 8'hFF);
		wr_ptr(1'h1, 8'h12);
		{lo_m, hi_m} = 16'hFF12;
		chk8(table_pointer_low_o, lo_m);
		chk8(table_pointer_high_o, hi_m);
		foreach (rows[i])
			run(rows[i]);
		$display("test rows done");
		// reset landing in the dummy slot must abandon the skip cleanly
		instr_valid_i = 1'h1;
		instr_op_i = OP_SKIP_IF_ZERO_LONG;
		mem_rdata_i = 8'h00;
		@(posedge clock_i);
		#5;
		instr_valid_i = 1'h0;
		chk1(skip_o, 1'h1);
		@(posedge clock_i);
		#5;
		reset_i = 1'h1;
		#1;
		chk1(instr_ready_o, 1'h1);
		chk1(dummy_cycle_o, 1'h0);
		chk8(accumulator_o, 8'h00);
		chk8(table_pointer_low_o, 8'h00);
		repeat (2) @(posedge clock_i);
		#5;
		reset_i = 1'h0;
		{acc_m, lo_m, hi_m, th_m, z_m} = 33'h0;
		run(row_t'{OP_SWAP_NIBBLES_INTO_ACC, 3'h0, 8'h12, 16'h0000, 1'h0});
		instr_valid_i = 1'h0;
		$display("test mid-run reset done");
		@(posedge clock_i);
		results();
	end
endmodule : test_ext_instr_swap_skip_table_xor
